// ---- slld_pkg.sv ----
// Package for the serial latch loader: word layout, select codes,
// field positions and reset values of the five write-only latches.
// Assumes a 24-bit word shifted in most significant bit first.
package slld_pkg;

  localparam int WORD_W = 24;

  // Select field
  localparam int SEL_LO_POS = 0;
  localparam int SEL_HI_POS = 2;
  localparam logic [1:0] SEL_CTRL = 2'h0;
  localparam logic [1:0] SEL_TX_CAL = 2'h1;
  localparam logic [1:0] SEL_SYNTH = 2'h2;
  localparam logic [1:0] SEL_FILTER = 2'h3;

  // Control word
  localparam int CTL_RXPD_POS = 22;
  localparam int CTL_PLLPD_POS = 21;
  localparam int CTL_OSCPD_POS = 20;
  localparam int CTL_TXPD_POS = 19;
  localparam int CTL_TXPWR_POS = 17;
  localparam int CTL_PUMPI_POS = 14;
  localparam int CTL_LOPWR_POS = 12;
  localparam int CTL_LOMUTE_POS = 11;
  localparam int CTL_TXMUTE_POS = 10;
  localparam int CTL_TRI_POS = 9;
  localparam int CTL_POL_POS = 8;
  localparam int CTL_TSEL_POS = 5;
  localparam int CTL_HOLD_POS = 4;

  // Transmit config word
  localparam int TX_DEMOD_POS = 21;
  localparam int TX_MIXER_POS = 18;
  localparam int TX_BSDIV_POS = 16;
  localparam int TX_REFDIV_POS = 3;
  localparam int REFDIV_W = 13;

  // Receive calibration word
  localparam int CAL_START_POS = 15;

  // Synth divider word
  localparam int SYN_MAIN_POS = 7;
  localparam int SYN_SWALLOW_POS = 2;
  localparam int MAINDIV_W = 13;
  localparam int SWALLOW_W = 5;

  // Reset values: everything powered down, LO output mute bit clear
  localparam logic [23:0] CTRL_RST = 24'h7C0004;
  localparam logic [23:0] TXCFG_RST = 24'hE30001;
  localparam logic [23:0] RXCAL_RST = 24'h000005;
  localparam logic [23:0] SYNTH_RST = 24'h000002;
  localparam logic [23:0] FILTER_RST = 24'h000003;

  // Destination of a load, one-hot
  typedef enum logic [4:0] {
    DEST_CTRL = 5'h01,
    DEST_TXCFG = 5'h02,
    DEST_RXCAL = 5'h04,
    DEST_SYNTH = 5'h08,
    DEST_FILTER = 5'h10
  } slld_dest_t;

  // Test output selector codes
  localparam logic [2:0] TSEL_LOW = 3'h0;
  localparam logic [2:0] TSEL_LOCK = 3'h1;
  localparam logic [2:0] TSEL_NOLOCK = 3'h2;
  localparam logic [2:0] TSEL_HIGH = 3'h7;

endpackage

// ---- slld_sync.sv ----
// Three-stage pin synchroniser with agreement filter and rise pulse.
// Assumes inputs are asynchronous to ref_clk.
`timescale 1ns/10ps
module slld_sync #(
  parameter int WIDTH = 4
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Pins
  input wire logic [WIDTH-1:0] din,
  // Filtered outputs
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise
);
  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;
  logic [WIDTH-1:0] stage3_reg;
  logic [WIDTH-1:0] level_reg;
  logic [WIDTH-1:0] level_next;
  logic [WIDTH-1:0] rise_reg;
  logic [WIDTH-1:0] rise_next;

  // Refused at elaboration, so a bad width never reaches a netlist
  if (WIDTH < 1) begin : g_width_check
    $error("slld_sync: WIDTH must be at least 1");
  end

  // A change counts only once stages two and three agree
  always_comb begin
    level_next = (~(stage2_reg ^ stage3_reg) & stage3_reg) | ((stage2_reg ^ stage3_reg) & level_reg);
    rise_next = level_next & ~level_reg;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
      stage3_reg <= '0;
      level_reg <= '0;
      rise_reg <= '0;
    end else begin
      stage1_reg <= din;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
      level_reg <= level_next;
      rise_reg <= rise_next;
    end
  end

  assign level = level_reg;
  assign rise = rise_reg;
endmodule // slld_sync

// ---- slld_loader.sv ----
// Serial latch loader: shift register, load decode, five latches and
// the decoded control and transmit fields they drive.
// Assumes the serial pins are asynchronous and slow against ref_clk.
`timescale 1ns/10ps
module slld_loader
  import slld_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Serial pins
  input wire logic serial_clk,
  input wire logic serial_data,
  input wire logic serial_load_strobe,
  // Lock status from the synthesiser
  input wire logic pll_lock,
  // Latch contents
  output logic [23:0] control_word,
  output logic [23:0] transmit_config_word,
  output logic [23:0] receive_calibration_word,
  output logic [23:0] synth_divider_word,
  output logic [23:0] receive_filter_word,
  // Control word fields
  output logic rx_filter_powerdown,
  output logic pll_powerdown,
  output logic osc_powerdown,
  output logic tx_section_powerdown,
  output logic [1:0] tx_power_sel,
  output logic [2:0] pump_current_sel,
  output logic [1:0] lo_power_sel,
  output logic pump_tristate,
  output logic detector_polarity,
  output logic divider_counters_hold,
  output logic test_output_pin,
  output logic lo_output_enable,
  output logic tx_output_enable,
  // Transmit config fields
  output logic [2:0] demod_phase_sel,
  output logic [2:0] mixer_phase_sel,
  output logic [1:0] bandsel_div,
  output logic [12:0] ref_div,
  // Synth divider fields
  output logic [12:0] main_div,
  output logic [4:0] swallow_div,
  // Calibration start, one cycle
  output logic cal_start
);

  // Destination decode, used by the load path and its checks
  function automatic slld_dest_t dest_of(input logic [2:0] sel);
    slld_dest_t d;
    d = DEST_CTRL;
    unique case (sel[1:0])
      SEL_CTRL: d = DEST_CTRL;
      SEL_TX_CAL: d = sel[SEL_HI_POS] ? DEST_RXCAL : DEST_TXCFG;
      SEL_SYNTH: d = DEST_SYNTH;
      SEL_FILTER: d = DEST_FILTER;
    endcase
    return d;
  endfunction

  logic [3:0] pin_level;
  logic [3:0] pin_rise;
  logic sclk_rise;
  logic load_rise;
  logic data_lvl;
  logic lock_lvl;

  // Pins resynchronised; data and clock share the same latency
  slld_sync #(
    .WIDTH(4)
  ) u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .din({pll_lock, serial_load_strobe, serial_data, serial_clk}),
    .level(pin_level),
    .rise(pin_rise)
  );

  assign sclk_rise = pin_rise[0];
  assign data_lvl = pin_level[1];
  assign load_rise = pin_rise[2];
  assign lock_lvl = pin_level[3];

  logic [23:0] shift_reg;
  logic [23:0] shift_next;
  logic [23:0] ctrl_reg;
  logic [23:0] ctrl_next;
  logic [23:0] txcfg_reg;
  logic [23:0] txcfg_next;
  logic [23:0] rxcal_reg;
  logic [23:0] rxcal_next;
  logic [23:0] synth_reg;
  logic [23:0] synth_next;
  logic [23:0] filter_reg;
  logic [23:0] filter_next;
  logic cal_start_reg;
  logic cal_start_next;
  logic lo_en_reg;
  logic lo_en_next;
  logic tx_en_reg;
  logic tx_en_next;
  logic test_out_reg;
  logic test_out_next;
  slld_dest_t dest;
  logic [4:0] load_vec;

  assign dest = dest_of(shift_reg[2:0]);
  assign load_vec = load_rise ? dest : 5'h00;

  // Shift and load; a load sees the word before any same-cycle shift
  always_comb begin
    shift_next = shift_reg;
    if (sclk_rise) begin
      // Oldest bit falls off the top, so only the last 24 remain
      shift_next = {shift_reg[22:0], data_lvl};
    end
    ctrl_next = load_vec[0] ? shift_reg : ctrl_reg;
    txcfg_next = load_vec[1] ? shift_reg : txcfg_reg;
    rxcal_next = load_vec[2] ? shift_reg : rxcal_reg;
    synth_next = load_vec[3] ? shift_reg : synth_reg;
    filter_next = load_vec[4] ? shift_reg : filter_reg;
    cal_start_next = load_vec[2] & shift_reg[CAL_START_POS];
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      shift_reg <= '0;
      ctrl_reg <= CTRL_RST;
      txcfg_reg <= TXCFG_RST;
      rxcal_reg <= RXCAL_RST;
      synth_reg <= SYNTH_RST;
      filter_reg <= FILTER_RST;
      cal_start_reg <= 1'b0;
    end else begin
      shift_reg <= shift_next;
      ctrl_reg <= ctrl_next;
      txcfg_reg <= txcfg_next;
      rxcal_reg <= rxcal_next;
      synth_reg <= synth_next;
      filter_reg <= filter_next;
      cal_start_reg <= cal_start_next;
    end
  end

  // Output muting and test output, one cycle behind the latch
  always_comb begin
    lo_en_next = ~(ctrl_reg[CTL_LOMUTE_POS] & ~lock_lvl);
    tx_en_next = ~(ctrl_reg[CTL_TXMUTE_POS] & ~lock_lvl);
    unique case (ctrl_reg[CTL_TSEL_POS +: 3])
      TSEL_LOCK: test_out_next = lock_lvl;
      TSEL_NOLOCK: test_out_next = ~lock_lvl;
      TSEL_HIGH: test_out_next = 1'b1;
      default: test_out_next = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lo_en_reg <= 1'b0;
      tx_en_reg <= 1'b0;
      test_out_reg <= 1'b0;
    end else begin
      lo_en_reg <= lo_en_next;
      tx_en_reg <= tx_en_next;
      test_out_reg <= test_out_next;
    end
  end

  assign control_word = ctrl_reg;
  assign transmit_config_word = txcfg_reg;
  assign receive_calibration_word = rxcal_reg;
  assign synth_divider_word = synth_reg;
  assign receive_filter_word = filter_reg;
  assign rx_filter_powerdown = ctrl_reg[CTL_RXPD_POS];
  assign pll_powerdown = ctrl_reg[CTL_PLLPD_POS];
  assign osc_powerdown = ctrl_reg[CTL_OSCPD_POS];
  assign tx_section_powerdown = ctrl_reg[CTL_TXPD_POS];
  assign tx_power_sel = ctrl_reg[CTL_TXPWR_POS +: 2];
  assign pump_current_sel = ctrl_reg[CTL_PUMPI_POS +: 3];
  assign lo_power_sel = ctrl_reg[CTL_LOPWR_POS +: 2];
  assign pump_tristate = ctrl_reg[CTL_TRI_POS];
  assign detector_polarity = ctrl_reg[CTL_POL_POS];
  assign divider_counters_hold = ctrl_reg[CTL_HOLD_POS];
  assign test_output_pin = test_out_reg;
  assign lo_output_enable = lo_en_reg;
  assign tx_output_enable = tx_en_reg;
  assign demod_phase_sel = txcfg_reg[TX_DEMOD_POS +: 3];
  assign mixer_phase_sel = txcfg_reg[TX_MIXER_POS +: 3];
  // Host must program 11 here; the value is passed on unchecked
  assign bandsel_div = txcfg_reg[TX_BSDIV_POS +: 2];
  assign ref_div = txcfg_reg[TX_REFDIV_POS +: REFDIV_W];
  // Range below 3 is the host's to avoid, not trapped here
  assign main_div = synth_reg[SYN_MAIN_POS +: MAINDIV_W];
  assign swallow_div = synth_reg[SYN_SWALLOW_POS +: SWALLOW_W];
  assign cal_start = cal_start_reg;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  a_shift_msb_first: assert property (
    sclk_rise |=> shift_reg == {$past(shift_reg[22:0]), $past(data_lvl)})
    else $error("shift register did not take the data bit");
  a_no_shift_idle: assert property (
    !sclk_rise |=> $stable(shift_reg))
    else $error("shift register moved without a clock edge");
  a_one_dest_only: assert property (
    load_rise |-> $onehot(load_vec))
    else $error("load did not pick exactly one latch");
  a_ctrl_load: assert property (
    load_rise && shift_reg[1:0] == SEL_CTRL |=> ctrl_reg == $past(shift_reg)
      && $stable(txcfg_reg) && $stable(synth_reg) && $stable(filter_reg))
    else $error("control load wrong or disturbed another latch");
  a_tx_or_cal: assert property (
    load_rise && shift_reg[1:0] == SEL_TX_CAL |=>
      (($past(shift_reg[2]) ? rxcal_reg : txcfg_reg) == $past(shift_reg)))
    else $error("bit two did not steer transmit or calibration");
  a_latch_hold: assert property (
    !load_rise |=> $stable(ctrl_reg) && $stable(txcfg_reg) && $stable(rxcal_reg)
      && $stable(synth_reg) && $stable(filter_reg))
    else $error("latch changed without a load");
  a_cal_pulse: assert property (
    load_rise && dest == DEST_RXCAL |=> cal_start == $past(shift_reg[CAL_START_POS]) ##1 !cal_start)
    else $error("calibration start wrong");
  a_lo_mute: assert property (
    ctrl_reg[CTL_LOMUTE_POS] && !lock_lvl |=> !lo_output_enable)
    else $error("LO output on before lock");
  a_tx_mute: assert property (
    ctrl_reg[CTL_TXMUTE_POS] && !lock_lvl |=> !tx_output_enable)
    else $error("transmit output on before lock");
  a_synth_load: assert property (
    load_rise && shift_reg[1:0] == SEL_SYNTH |=> synth_reg == $past(shift_reg))
    else $error("synth divider load failed");
  a_filter_load: assert property (
    load_rise && shift_reg[1:0] == SEL_FILTER |=> filter_reg == $past(shift_reg))
    else $error("filter word load failed");
  a_txcfg_fields: assert property (
    load_rise && dest == DEST_TXCFG |=> ref_div == $past(shift_reg[TX_REFDIV_POS +: REFDIV_W])
      && bandsel_div == $past(shift_reg[TX_BSDIV_POS +: 2]))
    else $error("transmit config fields not loaded");
  a_power_downs: assert property (
    load_rise && dest == DEST_CTRL |=> {rx_filter_powerdown, pll_powerdown, osc_powerdown,
      tx_section_powerdown} == $past(shift_reg[CTL_TXPD_POS +: 4]))
    else $error("power-down bits not taken from the control word");
  a_tx_power: assert property (
    load_rise && dest == DEST_CTRL |=>
      tx_power_sel == $past(shift_reg[CTL_TXPWR_POS +: 2]))
    else $error("transmit power select wrong");
  a_pump_current: assert property (
    load_rise && dest == DEST_CTRL |=>
      pump_current_sel == $past(shift_reg[CTL_PUMPI_POS +: 3]))
    else $error("pump current select wrong");
  a_lo_power: assert property (
    load_rise && dest == DEST_CTRL |=>
      lo_power_sel == $past(shift_reg[CTL_LOPWR_POS +: 2]))
    else $error("LO power select wrong");
  a_lo_unmute: assert property (
    !ctrl_reg[CTL_LOMUTE_POS] |=> lo_output_enable)
    else $error("LO output off with muting disabled");
  a_pump_tristate: assert property (
    load_rise && dest == DEST_CTRL |=> pump_tristate == $past(shift_reg[CTL_TRI_POS]))
    else $error("pump three-state bit wrong");
  a_detector_pol: assert property (
    load_rise && dest == DEST_CTRL |=> detector_polarity == $past(shift_reg[CTL_POL_POS]))
    else $error("detector polarity bit wrong");
  a_test_high: assert property (
    ctrl_reg[CTL_TSEL_POS +: 3] == TSEL_HIGH |=> test_output_pin)
    else $error("test output not high for the high code");
  a_test_lock: assert property (
    ctrl_reg[CTL_TSEL_POS +: 3] == TSEL_LOCK |=> test_output_pin == $past(lock_lvl))
    else $error("test output does not follow lock");
  a_counter_hold: assert property (
    load_rise && dest == DEST_CTRL |=>
      divider_counters_hold == $past(shift_reg[CTL_HOLD_POS]))
    else $error("counter hold bit wrong");
  a_demod_phase: assert property (
    load_rise && dest == DEST_TXCFG |=>
      demod_phase_sel == $past(shift_reg[TX_DEMOD_POS +: 3]))
    else $error("demodulator phase select wrong");
  a_mixer_phase: assert property (
    load_rise && dest == DEST_TXCFG |=>
      mixer_phase_sel == $past(shift_reg[TX_MIXER_POS +: 3]))
    else $error("mixer phase select wrong");
  a_synth_fields: assert property (
    load_rise && dest == DEST_SYNTH |=> swallow_div == $past(shift_reg[SYN_SWALLOW_POS +: SWALLOW_W])
      && main_div == $past(shift_reg[SYN_MAIN_POS +: MAINDIV_W]))
    else $error("synth divider fields not loaded");

  c_ctrl_load: cover property (load_rise && dest == DEST_CTRL);
  c_txcfg_load: cover property (load_rise && dest == DEST_TXCFG);
  c_cal_start: cover property (cal_start);
  c_lock_release: cover property (!lo_output_enable ##1 lo_output_enable);
  c_rxcal_load: cover property (load_rise && dest == DEST_RXCAL);

endmodule // slld_loader

// ---- slld_host_model.sv ----
// Host controller model: shifts words out on the serial pins.
// Assumes tasks are called from the testbench at a falling ref_clk edge.
`timescale 1ns/10ps
module slld_host_model (
  // Clock
  input wire logic ref_clk,
  // Serial pins
  output logic serial_clk,
  output logic serial_data,
  output logic serial_load_strobe
);
  initial begin
    serial_clk = 1'b0;
    serial_data = 1'b0;
    serial_load_strobe = 1'b0;
  end

  // Phases of four cycles or more, so no edge is lost in the synchroniser
  task automatic shift_word(input logic [23:0] w, input logic load);
    for (int i = 23; i >= 0; i--) begin
      @(negedge ref_clk);
      serial_data = w[i];
      repeat (4) @(negedge ref_clk);
      serial_clk = 1'b1;
      repeat (6) @(negedge ref_clk);
      serial_clk = 1'b0;
    end
    repeat (3) @(negedge ref_clk);
    // Released data shows the inverse, never a stale bit
    serial_data = ~serial_data;
    if (load) begin
      serial_load_strobe = 1'b1;
      repeat (6) @(negedge ref_clk);
      serial_load_strobe = 1'b0;
    end
  endtask
endmodule // slld_host_model

// ---- serial_latch_loader_tb_top.sv ----
// Testbench for the serial latch loader: writes words, checks latches.
// Assumes the host model and the design package are compiled first.
`timescale 1ns/10ps
module serial_latch_loader_tb_top
  import slld_pkg::*;
;
  logic ref_clk, rst, pll_lock, serial_clk, serial_data, serial_load_strobe;
  logic [23:0] control_word, transmit_config_word, receive_calibration_word;
  logic [23:0] synth_divider_word, receive_filter_word;
  logic rx_filter_powerdown, pll_powerdown, osc_powerdown, tx_section_powerdown;
  logic [1:0] tx_power_sel, lo_power_sel, bandsel_div;
  logic [2:0] pump_current_sel, demod_phase_sel, mixer_phase_sel, code;
  logic pump_tristate, detector_polarity, divider_counters_hold, test_output_pin;
  logic lo_output_enable, tx_output_enable, cal_start;
  logic [12:0] ref_div, main_div;
  logic [4:0] swallow_div;
  logic [23:0] exp_w [5];
  logic [2:0] codes [4] = '{3'h0, 3'h1, 3'h2, 3'h7};
  int mismatches = 0;
  int checks_done = 0;
  int cal_seen = 0;
  int n0;

  slld_host_model host_u (.ref_clk, .serial_clk, .serial_data, .serial_load_strobe);

  slld_loader dut_u (.ref_clk, .rst, .serial_clk, .serial_data, .serial_load_strobe,
    .pll_lock, .control_word, .transmit_config_word, .receive_calibration_word,
    .synth_divider_word, .receive_filter_word, .rx_filter_powerdown, .pll_powerdown,
    .osc_powerdown, .tx_section_powerdown, .tx_power_sel, .pump_current_sel, .lo_power_sel,
    .pump_tristate, .detector_polarity, .divider_counters_hold, .test_output_pin,
    .lo_output_enable, .tx_output_enable, .demod_phase_sel, .mixer_phase_sel, .bandsel_div,
    .ref_div, .main_div, .swallow_div, .cal_start);

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // One-cycle pulse, so count it on every edge
  always @(posedge ref_clk) begin
    if (cal_start === 1'b1) cal_seen++;
  end

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    if (mismatches == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check_all();
    check(control_word, exp_w[0]);
    check(transmit_config_word, exp_w[1]);
    check(receive_calibration_word, exp_w[2]);
    check(synth_divider_word, exp_w[3]);
    check(receive_filter_word, exp_w[4]);
  endtask

  // Latch output settles five edges after the strobe pin rises
  task automatic write_word(input logic [23:0] w);
    host_u.shift_word(w, 1'b1);
    repeat (12) @(negedge ref_clk);
    if (w[1:0] == 2'h0) exp_w[0] = w;
    else if (w[1:0] == 2'h2) exp_w[3] = w;
    else if (w[1:0] == 2'h3) exp_w[4] = w;
    else if (w[2]) exp_w[2] = w;
    else exp_w[1] = w;
    check_all();
  endtask

  task automatic check_ctrl();
    check({20'h0, rx_filter_powerdown, pll_powerdown, osc_powerdown, tx_section_powerdown},
      {20'h0, exp_w[0][22:19]});
    check({22'h0, tx_power_sel}, {22'h0, exp_w[0][18:17]});
    check({21'h0, pump_current_sel}, {21'h0, exp_w[0][16:14]});
    check({22'h0, lo_power_sel}, {22'h0, exp_w[0][13:12]});
    check({21'h0, pump_tristate, detector_polarity, divider_counters_hold},
      {21'h0, exp_w[0][9], exp_w[0][8], exp_w[0][4]});
  endtask

  initial begin
    repeat (100000) @(posedge ref_clk);
    mismatches++;
    conclude();
  end

  initial begin
    rst = 1'b1;
    pll_lock = 1'b0;
    exp_w = '{CTRL_RST, TXCFG_RST, RXCAL_RST, SYNTH_RST, FILTER_RST};
    repeat (3) @(negedge ref_clk);
    rst = 1'b0;
    repeat (6) @(negedge ref_clk);
    check_all();
    // Spare bits always written as 0,1
    write_word(24'h3CA5A4);
    check_ctrl();
    write_word(24'h435A54);
    check_ctrl();
    // Mute bits set: enables follow lock; test output over codes 0, 1, 2 and 7
    for (int l = 0; l < 2; l++) begin
      pll_lock = l[0];
      for (int k = 0; k < 4; k++) begin
        code = codes[k];
        write_word(24'h000C04 | {16'h0, code, 5'h0});
        check({23'h0, test_output_pin}, {23'h0, (code == 3'h7) | ((code == 3'h1) & pll_lock)
          | ((code == 3'h2) & !pll_lock)});
        check({22'h0, lo_output_enable, tx_output_enable}, {22'h0, pll_lock, pll_lock});
      end
    end
    pll_lock = 1'b0;
    write_word(24'h000004);
    check({22'h0, lo_output_enable, tx_output_enable}, 24'h000003);
    // Band-select held at 11 by the host
    write_word(24'h9F2A79);
    check({21'h0, demod_phase_sel}, {21'h0, exp_w[1][23:21]});
    check({21'h0, mixer_phase_sel}, {21'h0, exp_w[1][20:18]});
    check({9'h0, bandsel_div, ref_div}, {9'h0, exp_w[1][17:3]});
    n0 = cal_seen;
    write_word(24'hE38005);
    check(24'(cal_seen - n0), 24'h000001);
    write_word(24'h0A7F0D);
    check(24'(cal_seen - n0), 24'h000001);
    // Main divider kept within 3..8191
    write_word(24'h0FFFFE);
    check({6'h0, main_div, swallow_div}, {6'h0, 13'h1FFF, 5'h1F});
    write_word(24'h000182);
    check({6'h0, main_div, swallow_div}, {6'h0, 13'h0003, 5'h00});
    write_word(24'hABCDE7);
    // Shifting without a load, then 48 clocks before one load
    host_u.shift_word(24'h5A5A58, 1'b0);
    repeat (12) @(negedge ref_clk);
    check_all();
    write_word(24'hC3C3C7);
    // Second reset mid-run restores every latch
    rst = 1'b1;
    exp_w = '{CTRL_RST, TXCFG_RST, RXCAL_RST, SYNTH_RST, FILTER_RST};
    repeat (3) @(negedge ref_clk);
    rst = 1'b0;
    repeat (2) @(negedge ref_clk);
    check_all();
    conclude();
  end
endmodule // serial_latch_loader_tb_top
